// File: logic/iot_defs.svh
// Timing table constants for the integer operation timing model
`ifndef IOT_DEFS_SVH
`define IOT_DEFS_SVH
// Packed as head(8) tail(8) total(8) reads(4) prefetches(4) writes(4)
`define IOT_T_BASIC        36'h00_00_02_0_1_0
`define IOT_T_ALU_MEM      36'h00_03_05_0_1_1
`define IOT_T_HEAD2_REG    36'h02_00_04_0_1_0
`define IOT_T_DEC_MEM      36'h02_02_0c_2_1_1
`define IOT_T_XARITH_MEM   36'h02_02_0a_2_1_1
`define IOT_T_CMP_MEM      36'h01_00_08_2_1_0
`define IOT_T_CLEAR_MEM    36'h00_02_04_0_1_1
`define IOT_T_TAIL2_MEM    36'h00_02_06_0_1_1
`define IOT_T_SCC_MEM      36'h02_02_06_0_1_1
`define IOT_T_HEAD4_REG    36'h04_00_06_0_1_0
`define IOT_T_TSET_MEM     36'h01_00_0a_0_1_1
`define IOT_T_BMOD_IMM_REG 36'h02_00_06_0_2_0
`define IOT_T_BMOD_IMM_MEM 36'h01_02_08_0_2_1
`define IOT_T_BMOD_REG_MEM 36'h02_02_08_0_1_1
`define IOT_T_BCHK_IMM_REG 36'h02_00_04_0_2_0
`define IOT_T_BCHK_IMM_MEM 36'h01_00_04_0_2_0
`define IOT_T_BCHK_REG_MEM 36'h02_00_08_0_1_0
`define IOT_T_COUNTED      36'h00_00_00_0_1_0
// Long variable operand: extra clocks on tail and total, and bus cycles
`define IOT_LONG_ADD       8'h02
`define IOT_LONG_CYCLES    4'h2
`define IOT_MIN_CLOCKS     8'h06
`define IOT_SHIFT_BASE     8'h03
`define IOT_ROTX_IMM_BASE  8'h02
`define IOT_ROTX_IMM_MAX   6'h08
`define IOT_SEQ_WIDTH      16
`endif

// File: logic/iot_pkg.sv
// Types for the integer operation timing model
package iot_pkg;
    typedef enum logic [4:0] {
        OP_MOVE_QUICK, OP_ADD_QUICK, OP_SUBTRACT_QUICK, OP_IMM_ALU,
        OP_DECIMAL_ARITH, OP_EXTEND_ARITH, OP_MEMORY_COMPARE, OP_CLEAR_OPERAND,
        OP_NEGATE_GROUP, OP_SIGN_WIDEN, OP_DECIMAL_NEGATE, OP_SET_COND,
        OP_TEST_AND_SET, OP_OPERAND_TEST, OP_SHIFT_ROTATE, OP_ROTATE_EXTEND,
        OP_BIT_MODIFY, OP_BIT_TEST
    } iot_op_t;

    typedef struct packed {
        logic [7:0] head;
        logic [7:0] tail;
        logic [7:0] total;
        logic [3:0] reads;
        logic [3:0] prefetch;
        logic [3:0] writes;
    } iot_entry_t;

    typedef struct packed {
        iot_op_t    op;
        logic       memDst;
        logic       immSrc;
        logic       isLong;
        logic [5:0] count;
        logic [7:0] immClocks;
        logic [7:0] eaClocks;
    } iot_req_t;

    typedef struct packed {
        logic [7:0] head;
        logic [7:0] tail;
        logic [9:0] total;
        logic [3:0] reads;
        logic [3:0] prefetch;
        logic [3:0] writes;
        logic [7:0] overlap;
    } iot_res_t;
endpackage

// File: logic/iot_timing.sv
// Integer operation clock-count model with tail/head overlap accumulation
// Functional notes
// [RL1] Register quick/immediate forms: 2 clocks, one prefetch
// [RL2] Memory quick/immediate forms: 5 clocks, tail 3
// [RL3] Variable access: one cycle, two for long
// [RL4] Long variable access adds two tail clocks
// [RL5] Immediate forms add immediate fetch time
// [RL6] Bus counts fit inside total clocks
// [RL7] Decimal add/subtract: 4 register, 12 memory
// [RL8] Extend add/subtract: 2 register, 10 memory
// [RL9] Memory compare: 8 clocks, two reads
// [RL10] Clear: 4 memory, 2 register
// [RL11] Test-and-set: 10 memory, 6 register
// [RL12] Set-on-condition: 4 register, 6 memory
// [RL13] Negate groups: decimal 6, others 5 memory
// [RL14] Shift time ignores count except counted forms
// [RL15] Immediate shifts 6 clocks head 4
// [RL16] Register-count shift uses banded formula, minimum 6
// [RL17] Counts up to 6 band 6, 63 gives 22
// [RL18] Rotate-extend register count: max(3+n+even,6)
// [RL19] Rotate-extend immediate count: max(2+n+odd,6), n capped at 8
// [RL20] Bit modify on register: 6 clocks
// [RL21] Bit modify on memory: 8 clocks
// [RL22] Bit test: 4 or 8 clocks
// [RL23] Tail overlaps next head in sequence sum
`timescale 1ns/1ps
`default_nettype none
`include "iot_defs.svh"
module iot_timing #(
    parameter int SEQ_WIDTH = `IOT_SEQ_WIDTH
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             reqValid,
    input  wire iot_pkg::iot_req_t reqInfo,
    input  wire logic             seqClear,
    output logic                  resValid,
    output iot_pkg::iot_res_t     resInfo,
    output logic [SEQ_WIDTH-1:0]  seqClocks
);
    if (SEQ_WIDTH < 10) begin : g_bad_width
        $error("SEQ_WIDTH must hold at least one total clock count");
    end

    function automatic logic [7:0] maxSix(input logic [7:0] v);
        maxSix = (v < `IOT_MIN_CLOCKS) ? `IOT_MIN_CLOCKS : v;
    endfunction

    // Only memory forms reached through an effective address pay its fetch time
    function automatic logic needsEa(input iot_pkg::iot_op_t op);
        needsEa = !(op == iot_pkg::OP_DECIMAL_ARITH || op == iot_pkg::OP_EXTEND_ARITH ||
                    op == iot_pkg::OP_MEMORY_COMPARE);
    endfunction

    logic                  acc;
    iot_pkg::iot_entry_t   tb;
    logic                  varAccess;
    logic [7:0]            counted;
    logic                  useCounted;
    logic [7:0]            nBand;
    logic [7:0]            nRot;
    logic [9:0]            totalCalc;
    logic [7:0]            tailCalc;
    logic [7:0]            ovl;
    logic [7:0]            prevTail;
    logic [SEQ_WIDTH-1:0]  seqBase;
    iot_pkg::iot_res_t     res_nxt;
    logic                  resValid_nxt;
    logic [SEQ_WIDTH-1:0]  seq_nxt;
    logic [7:0]            prevTail_nxt;
    iot_pkg::iot_req_t     lastReq_nxt;
    logic [SEQ_WIDTH-1:0]  seqPrev_nxt;
    logic                  restart_nxt;

    logic                  resValid_r;
    iot_pkg::iot_res_t     res_r;
    logic [SEQ_WIDTH-1:0]  seq_r;
    logic [7:0]            prevTail_r;
    iot_pkg::iot_req_t     lastReq_r;
    logic [SEQ_WIDTH-1:0]  seqPrev_r;
    logic                  restart_r;

    assign acc = reqValid;

    always_comb begin
        tb         = `IOT_T_BASIC;
        varAccess  = 1'b0;
        useCounted = 1'b0;
        nBand      = {4'h0, reqInfo.count[5:2]} + {6'h0, reqInfo.count[1:0]};
        nRot       = {2'h0, (reqInfo.count > `IOT_ROTX_IMM_MAX) ? `IOT_ROTX_IMM_MAX : reqInfo.count};
        counted    = `IOT_MIN_CLOCKS;
        case (reqInfo.op)
            iot_pkg::OP_MOVE_QUICK, iot_pkg::OP_SIGN_WIDEN, iot_pkg::OP_OPERAND_TEST: begin
                tb = `IOT_T_BASIC;
            end
            iot_pkg::OP_ADD_QUICK, iot_pkg::OP_SUBTRACT_QUICK, iot_pkg::OP_IMM_ALU: begin
                tb = reqInfo.memDst ? `IOT_T_ALU_MEM : `IOT_T_BASIC; // [RL1] [RL2]
                varAccess = reqInfo.memDst;
            end
            iot_pkg::OP_DECIMAL_ARITH: begin
                tb = reqInfo.memDst ? `IOT_T_DEC_MEM : `IOT_T_HEAD2_REG; // [RL7]
            end
            iot_pkg::OP_EXTEND_ARITH: begin
                tb = reqInfo.memDst ? `IOT_T_XARITH_MEM : `IOT_T_BASIC; // [RL8]
            end
            iot_pkg::OP_MEMORY_COMPARE: begin
                tb = `IOT_T_CMP_MEM; // [RL9]
            end
            iot_pkg::OP_CLEAR_OPERAND: begin
                tb = reqInfo.memDst ? `IOT_T_CLEAR_MEM : `IOT_T_BASIC; // [RL10]
                varAccess = reqInfo.memDst;
            end
            iot_pkg::OP_NEGATE_GROUP: begin
                tb = reqInfo.memDst ? `IOT_T_ALU_MEM : `IOT_T_BASIC; // [RL13]
                varAccess = reqInfo.memDst;
            end
            iot_pkg::OP_DECIMAL_NEGATE: begin
                tb = reqInfo.memDst ? `IOT_T_TAIL2_MEM : `IOT_T_HEAD2_REG; // [RL13]
            end
            iot_pkg::OP_SET_COND: begin
                tb = reqInfo.memDst ? `IOT_T_SCC_MEM : `IOT_T_HEAD2_REG; // [RL12]
            end
            iot_pkg::OP_TEST_AND_SET: begin
                tb = reqInfo.memDst ? `IOT_T_TSET_MEM : `IOT_T_HEAD4_REG; // [RL11]
            end
            iot_pkg::OP_SHIFT_ROTATE: begin
                // Count only matters for the register-count form [RL14]
                if (reqInfo.memDst) begin
                    tb = `IOT_T_TAIL2_MEM; // [RL15]
                end else if (reqInfo.immSrc) begin
                    tb = `IOT_T_HEAD4_REG; // [RL15]
                end else begin
                    tb = `IOT_T_COUNTED;
                    useCounted = 1'b1;
                    counted = maxSix(`IOT_SHIFT_BASE + nBand + {7'h0, ~nBand[0]}); // [RL16] [RL17]
                end
            end
            iot_pkg::OP_ROTATE_EXTEND: begin
                if (reqInfo.memDst) begin
                    tb = `IOT_T_TAIL2_MEM;
                end else if (reqInfo.immSrc) begin
                    tb = `IOT_T_COUNTED;
                    useCounted = 1'b1;
                    counted = maxSix(`IOT_ROTX_IMM_BASE + nRot + {7'h0, nRot[0]}); // [RL19]
                end else begin
                    tb = `IOT_T_COUNTED;
                    useCounted = 1'b1;
                    counted = maxSix(`IOT_SHIFT_BASE + {2'h0, reqInfo.count} +
                                     {7'h0, ~reqInfo.count[0]}); // [RL18]
                end
            end
            iot_pkg::OP_BIT_MODIFY: begin
                case ({reqInfo.memDst, reqInfo.immSrc})
                    2'h0:    tb = `IOT_T_HEAD4_REG; // [RL20]
                    2'h1:    tb = `IOT_T_BMOD_IMM_REG; // [RL20]
                    2'h2:    tb = `IOT_T_BMOD_REG_MEM; // [RL21]
                    default: tb = `IOT_T_BMOD_IMM_MEM; // [RL21]
                endcase
            end
            iot_pkg::OP_BIT_TEST: begin
                case ({reqInfo.memDst, reqInfo.immSrc})
                    2'h0:    tb = `IOT_T_HEAD2_REG; // [RL22]
                    2'h1:    tb = `IOT_T_BCHK_IMM_REG; // [RL22]
                    2'h2:    tb = `IOT_T_BCHK_REG_MEM; // [RL22]
                    default: tb = `IOT_T_BCHK_IMM_MEM; // [RL22]
                endcase
            end
            default: begin
                tb = `IOT_T_BASIC;
            end
        endcase
        if (useCounted) begin
            tb.head  = counted; // [RL16]
            tb.total = counted;
        end
        tailCalc  = tb.tail;
        totalCalc = {2'h0, tb.total};
        if (varAccess && reqInfo.isLong) begin
            tb.writes = `IOT_LONG_CYCLES; // [RL3]
            tailCalc  = tb.tail + `IOT_LONG_ADD; // [RL4]
            totalCalc = totalCalc + {2'h0, `IOT_LONG_ADD}; // [RL4]
        end
        if (reqInfo.memDst && needsEa(reqInfo.op)) begin
            totalCalc = totalCalc + {2'h0, reqInfo.eaClocks};
        end
        if (reqInfo.immSrc && (reqInfo.op == iot_pkg::OP_IMM_ALU || reqInfo.op == iot_pkg::OP_BIT_MODIFY ||
                               reqInfo.op == iot_pkg::OP_BIT_TEST)) begin
            totalCalc = totalCalc + {2'h0, reqInfo.immClocks}; // [RL5]
        end
    end

    // Overlap never exceeds either side; a cleared sequence starts with none
    always_comb begin
        prevTail = seqClear ? 8'h00 : prevTail_r;
        seqBase  = seqClear ? '0 : seq_r;
        ovl      = (prevTail < tb.head) ? prevTail : tb.head; // [RL23]
        res_nxt          = res_r;
        resValid_nxt     = 1'b0;
        seq_nxt          = seqClear ? '0 : seq_r;
        prevTail_nxt     = seqClear ? 8'h00 : prevTail_r;
        lastReq_nxt      = lastReq_r;
        seqPrev_nxt      = seqPrev_r;
        restart_nxt      = restart_r;
        if (acc) begin
            resValid_nxt     = 1'b1;
            res_nxt.head     = tb.head;
            res_nxt.tail     = tailCalc;
            res_nxt.total    = totalCalc;
            res_nxt.reads    = tb.reads;
            res_nxt.prefetch = tb.prefetch;
            res_nxt.writes   = tb.writes;
            res_nxt.overlap  = ovl;
            seq_nxt          = SEQ_WIDTH'(seqBase + SEQ_WIDTH'(totalCalc) - SEQ_WIDTH'(ovl)); // [RL23]
            prevTail_nxt     = tailCalc;
            lastReq_nxt      = reqInfo;
            seqPrev_nxt      = seqBase;
            restart_nxt      = seqClear;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            resValid_r <= 1'b0;
            res_r      <= '0;
            seq_r      <= '0;
            prevTail_r <= 8'h00;
            lastReq_r  <= '0;
            seqPrev_r  <= '0;
            restart_r  <= 1'b0;
        end else if (ce) begin
            resValid_r <= resValid_nxt;
            res_r      <= res_nxt;
            seq_r      <= seq_nxt;
            prevTail_r <= prevTail_nxt;
            lastReq_r  <= lastReq_nxt;
            seqPrev_r  <= seqPrev_nxt;
            restart_r  <= restart_nxt;
        end
    end

    assign resValid  = resValid_r;
    assign resInfo   = res_r;
    assign seqClocks = seq_r;

    chk_quick_reg: assert property (@(posedge clock) disable iff (rst) // [RL1]
        resValid_r && lastReq_r.op == iot_pkg::OP_ADD_QUICK && !lastReq_r.memDst
        |-> res_r.total == 10'h002 && res_r.head == 8'h00 && res_r.prefetch == 4'h1 && res_r.writes == 4'h0)
        else $error("register quick form timing wrong");

    chk_mem_tail: assert property (@(posedge clock) disable iff (rst) // [RL2] [RL4]
        resValid_r && lastReq_r.op == iot_pkg::OP_SUBTRACT_QUICK && lastReq_r.memDst
        |-> res_r.head == 8'h00 && res_r.tail == (lastReq_r.isLong ? 8'h05 : 8'h03)
            && res_r.total == 10'h005 + (lastReq_r.isLong ? 10'h002 : 10'h000) + {2'h0, lastReq_r.eaClocks})
        else $error("memory quick form tail or total wrong");

    chk_var_writes: assert property (@(posedge clock) disable iff (rst) // [RL3]
        resValid_r && lastReq_r.memDst && (lastReq_r.op == iot_pkg::OP_CLEAR_OPERAND ||
            lastReq_r.op == iot_pkg::OP_NEGATE_GROUP)
        |-> res_r.writes == (lastReq_r.isLong ? 4'h2 : 4'h1))
        else $error("variable write count wrong");

    chk_bus_fits: assert property (@(posedge clock) disable iff (rst) // [RL6]
        resValid_r |-> {res_r.reads, 1'b0} + {res_r.prefetch, 1'b0} + {res_r.writes, 1'b0} <= res_r.total)
        else $error("bus cycles exceed total clocks");

    chk_dec_mem: assert property (@(posedge clock) disable iff (rst) // [RL7]
        resValid_r && lastReq_r.op == iot_pkg::OP_DECIMAL_ARITH && lastReq_r.memDst
        |-> res_r.total == 10'h00c && res_r.reads == 4'h2 && res_r.tail == 8'h02)
        else $error("decimal memory form timing wrong");

    chk_cmp_mem: assert property (@(posedge clock) disable iff (rst) // [RL9]
        resValid_r && lastReq_r.op == iot_pkg::OP_MEMORY_COMPARE
        |-> res_r.total == 10'h008 && res_r.head == 8'h01 && res_r.reads == 4'h2)
        else $error("memory compare timing wrong");

    chk_shift_band: assert property (@(posedge clock) disable iff (rst) // [RL16] [RL17]
        resValid_r && lastReq_r.op == iot_pkg::OP_SHIFT_ROTATE && !lastReq_r.memDst && !lastReq_r.immSrc
        |-> res_r.head == res_r.total[7:0] && (lastReq_r.count != 6'h3f || res_r.total == 10'h016)
            && (lastReq_r.count > 6'h06 || res_r.total == 10'h006))
        else $error("register-count shift band wrong");

    chk_rotx_even: assert property (@(posedge clock) disable iff (rst) // [RL18] [RL19]
        resValid_r && lastReq_r.op == iot_pkg::OP_ROTATE_EXTEND && !lastReq_r.memDst
        |-> !res_r.total[0] && res_r.total >= 10'h006 && res_r.head == res_r.total[7:0])
        else $error("rotate-with-extend count timing wrong");

    chk_bit_mem: assert property (@(posedge clock) disable iff (rst) // [RL21]
        resValid_r && lastReq_r.op == iot_pkg::OP_BIT_MODIFY && lastReq_r.memDst
        |-> res_r.prefetch == (lastReq_r.immSrc ? 4'h2 : 4'h1) && res_r.writes == 4'h1 && res_r.tail == 8'h02)
        else $error("bit modify memory timing wrong");

    chk_seq_sum: assert property (@(posedge clock) disable iff (rst) // [RL23]
        resValid_r |-> seq_r == SEQ_WIDTH'(seqPrev_r + SEQ_WIDTH'(res_r.total) - SEQ_WIDTH'(res_r.overlap))
            && res_r.overlap <= res_r.head)
        else $error("sequence overlap sum wrong");

    // A restarted sequence carries no earlier tail into its sum
    chk_restart_sum: assert property (@(posedge clock) disable iff (rst) // [RL23]
        resValid_r && restart_r |-> res_r.overlap == 8'h00 && seq_r == SEQ_WIDTH'(res_r.total))
        else $error("restarted sequence sum wrong");

    chk_bit_test: assert property (@(posedge clock) disable iff (rst) // [RL22]
        resValid_r && lastReq_r.op == iot_pkg::OP_BIT_TEST && !lastReq_r.memDst
        |-> res_r.head == 8'h02 && res_r.writes == 4'h0 && res_r.prefetch == (lastReq_r.immSrc ? 4'h2 : 4'h1))
        else $error("bit test register timing wrong");
endmodule
`default_nettype wire

// File: sim/iot_issue_model.sv
// Instruction issue model that feeds requests to the timing block
`timescale 1ns/1ps
`default_nettype none
module iot_issue_model (
    input  wire logic         clock,
    output logic              reqValid,
    output iot_pkg::iot_req_t reqInfo,
    output logic              seqClear
);
    initial begin
        reqValid = 1'b0;
        reqInfo  = '0;
        seqClear = 1'b0;
    end

    // Request stands for one edge; calls may follow each other back to back
    task automatic send(input iot_pkg::iot_req_t r, input logic restart);
        reqValid <= 1'b1;
        reqInfo  <= r;
        seqClear <= restart;
        @(posedge clock);
    endtask

    // Info is scrambled when idle so stale fields cannot pass for a request
    task automatic idle();
        reqValid <= 1'b0;
        seqClear <= 1'b0;
        reqInfo  <= iot_pkg::iot_req_t'(~reqInfo);
    endtask
endmodule
`default_nettype wire

// File: sim/test_integer_op_cycle_timing.sv
// Self-checking bench for the integer operation timing model
`timescale 1ns/1ps
`default_nettype none
module test_integer_op_cycle_timing;
    localparam logic [7:0] IMC = 8'h03;
    localparam logic [7:0] EAC = 8'h04;
    logic              clock;
    logic              rst;
    logic              ce;
    logic              reqValid;
    iot_pkg::iot_req_t reqInfo;
    logic              seqClear;
    logic              resValid;
    iot_pkg::iot_res_t resInfo;
    logic [15:0]       seqClocks;
    int                fails;
    int                n_compared;

    iot_issue_model issuer (.clock(clock), .reqValid(reqValid), .reqInfo(reqInfo), .seqClear(seqClear));
    iot_timing #(.SEQ_WIDTH(16)) dut (.clock(clock), .rst(rst), .ce(ce), .reqValid(reqValid),
        .reqInfo(reqInfo), .seqClear(seqClear), .resValid(resValid), .resInfo(resInfo),
        .seqClocks(seqClocks));

    initial clock = 1'b0;
    always #2.5 clock = ~clock;

    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        n_compared++;
        if (seen !== want) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic complete_run();
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    function automatic iot_pkg::iot_req_t rq(input iot_pkg::iot_op_t op, input logic m, input logic i,
        input logic l, input logic [5:0] n);
        rq = '{op, m, i, l, n, IMC, EAC};
    endfunction

    // Each case starts a fresh sequence, so overlap is 0 and the sum is the total
    task automatic tc(input iot_pkg::iot_op_t op, input logic m, input logic i, input logic l,
        input logic [5:0] n, input logic [7:0] h, input logic [7:0] t, input logic [9:0] tot,
        input logic [3:0] r, input logic [3:0] p, input logic [3:0] w);
        issuer.send(rq(op, m, i, l, n), 1'b1);
        issuer.idle();
        #1;
        check(64'(resValid), 64'h1);
        check(64'(resInfo), 64'({h, t, tot, r, p, w, 8'h00}));
        check(64'(seqClocks), 64'(tot));
        @(posedge clock);
    endtask

    // Totals below fold in immediate time 3 and address time 4 where they apply
    task automatic test_table();
        tc(iot_pkg::OP_MOVE_QUICK,0,1,0,0, 0,0,2,0,1,0);
        tc(iot_pkg::OP_SIGN_WIDEN,0,0,0,0, 0,0,2,0,1,0);
        tc(iot_pkg::OP_OPERAND_TEST,1,0,0,0, 0,0,6,0,1,0);
        tc(iot_pkg::OP_ADD_QUICK,0,1,0,0, 0,0,2,0,1,0);
        tc(iot_pkg::OP_SUBTRACT_QUICK,0,1,0,0, 0,0,2,0,1,0);
        tc(iot_pkg::OP_IMM_ALU,0,1,0,0, 0,0,5,0,1,0);
        tc(iot_pkg::OP_ADD_QUICK,1,1,0,0, 0,3,9,0,1,1);
        tc(iot_pkg::OP_IMM_ALU,1,1,0,0, 0,3,12,0,1,1);
        tc(iot_pkg::OP_SUBTRACT_QUICK,1,1,1,0, 0,5,11,0,1,2);
        tc(iot_pkg::OP_IMM_ALU,1,1,1,0, 0,5,14,0,1,2);
        tc(iot_pkg::OP_DECIMAL_ARITH,0,0,0,0, 2,0,4,0,1,0);
        tc(iot_pkg::OP_DECIMAL_ARITH,1,0,0,0, 2,2,12,2,1,1);
        tc(iot_pkg::OP_EXTEND_ARITH,0,0,0,0, 0,0,2,0,1,0);
        tc(iot_pkg::OP_EXTEND_ARITH,1,0,0,0, 2,2,10,2,1,1);
        tc(iot_pkg::OP_MEMORY_COMPARE,1,0,0,0, 1,0,8,2,1,0);
        tc(iot_pkg::OP_CLEAR_OPERAND,0,0,0,0, 0,0,2,0,1,0);
        tc(iot_pkg::OP_CLEAR_OPERAND,1,0,0,0, 0,2,8,0,1,1);
        tc(iot_pkg::OP_CLEAR_OPERAND,1,0,1,0, 0,4,10,0,1,2);
        tc(iot_pkg::OP_TEST_AND_SET,0,0,0,0, 4,0,6,0,1,0);
        tc(iot_pkg::OP_TEST_AND_SET,1,0,0,0, 1,0,14,0,1,1);
        tc(iot_pkg::OP_SET_COND,0,0,0,0, 2,0,4,0,1,0);
        tc(iot_pkg::OP_SET_COND,1,0,1,0, 2,2,10,0,1,1);
        tc(iot_pkg::OP_DECIMAL_NEGATE,0,0,0,0, 2,0,4,0,1,0);
        tc(iot_pkg::OP_DECIMAL_NEGATE,1,0,0,0, 0,2,10,0,1,1);
        tc(iot_pkg::OP_NEGATE_GROUP,1,0,0,0, 0,3,9,0,1,1);
        tc(iot_pkg::OP_NEGATE_GROUP,1,0,1,0, 0,5,11,0,1,2);
        tc(iot_pkg::OP_SHIFT_ROTATE,0,1,0,7, 4,0,6,0,1,0);
        tc(iot_pkg::OP_SHIFT_ROTATE,1,0,0,13, 0,2,10,0,1,1);
        tc(iot_pkg::OP_SHIFT_ROTATE,0,0,0,0, 6,0,6,0,1,0);
        tc(iot_pkg::OP_SHIFT_ROTATE,0,0,0,12, 6,0,6,0,1,0);
        tc(iot_pkg::OP_SHIFT_ROTATE,0,0,0,7, 8,0,8,0,1,0);
        tc(iot_pkg::OP_SHIFT_ROTATE,0,0,0,13, 8,0,8,0,1,0);
        tc(iot_pkg::OP_SHIFT_ROTATE,0,0,0,63, 22,0,22,0,1,0);
        tc(iot_pkg::OP_ROTATE_EXTEND,0,0,0,0, 6,0,6,0,1,0);
        tc(iot_pkg::OP_ROTATE_EXTEND,0,0,0,4, 8,0,8,0,1,0);
        tc(iot_pkg::OP_ROTATE_EXTEND,0,0,0,63, 66,0,66,0,1,0);
        tc(iot_pkg::OP_ROTATE_EXTEND,0,1,0,2, 6,0,6,0,1,0);
        tc(iot_pkg::OP_ROTATE_EXTEND,0,1,0,5, 8,0,8,0,1,0);
        tc(iot_pkg::OP_ROTATE_EXTEND,0,1,0,8, 10,0,10,0,1,0);
        tc(iot_pkg::OP_ROTATE_EXTEND,0,1,0,9, 10,0,10,0,1,0);
        tc(iot_pkg::OP_ROTATE_EXTEND,1,0,0,0, 0,2,10,0,1,1);
        tc(iot_pkg::OP_BIT_MODIFY,0,1,0,0, 2,0,9,0,2,0);
        tc(iot_pkg::OP_BIT_MODIFY,0,0,0,0, 4,0,6,0,1,0);
        tc(iot_pkg::OP_BIT_MODIFY,1,1,0,0, 1,2,15,0,2,1);
        tc(iot_pkg::OP_BIT_MODIFY,1,0,0,0, 2,2,12,0,1,1);
        tc(iot_pkg::OP_BIT_TEST,0,1,0,0, 2,0,7,0,2,0);
        tc(iot_pkg::OP_BIT_TEST,0,0,0,0, 2,0,4,0,1,0);
        tc(iot_pkg::OP_BIT_TEST,1,1,0,0, 1,0,11,0,2,0);
        tc(iot_pkg::OP_BIT_TEST,1,0,0,0, 2,0,12,0,1,0);
        $display("test_table done");
    endtask

    // Back-to-back pairs: tail 5 under head 22, then tail 2 under head 4
    task automatic test_overlap();
        issuer.send(rq(iot_pkg::OP_ADD_QUICK, 1, 1, 1, 0), 1'b1);
        issuer.send(rq(iot_pkg::OP_SHIFT_ROTATE, 0, 0, 0, 63), 1'b0);
        issuer.idle();
        #1;
        check(64'(resInfo.overlap), 64'h5);
        check(64'(seqClocks), 64'h1c);
        @(posedge clock);
        issuer.send(rq(iot_pkg::OP_SHIFT_ROTATE, 1, 0, 0, 0), 1'b0);
        issuer.send(rq(iot_pkg::OP_BIT_MODIFY, 0, 0, 0, 0), 1'b0);
        issuer.idle();
        #1;
        check(64'(resInfo.overlap), 64'h2);
        check(64'(seqClocks), 64'h2a);
        @(posedge clock);
        $display("test_overlap done");
    endtask

    // With the clock enable low a request is ignored and the sum holds
    task automatic test_hold();
        ce <= 1'b0;
        issuer.send(rq(iot_pkg::OP_TEST_AND_SET, 0, 0, 0, 0), 1'b1);
        issuer.idle();
        #1;
        check(64'(resValid), 64'h0);
        check(64'(resInfo.total), 64'h6);
        check(64'(seqClocks), 64'h2a);
        @(posedge clock);
        ce <= 1'b1;
        @(posedge clock);
        $display("test_hold done");
    endtask

    // A second reset in mid-run beats a request at the same edge and clears every output
    task automatic test_reset();
        rst <= 1'b1;
        issuer.send(rq(iot_pkg::OP_CLEAR_OPERAND, 1, 0, 0, 0), 1'b0);
        issuer.idle();
        #1;
        check(64'(resValid), 64'h0);
        check(64'(resInfo), 64'h0);
        check(64'(seqClocks), 64'h0);
        @(posedge clock);
        rst <= 1'b0;
        tc(iot_pkg::OP_ADD_QUICK,0,1,0,0, 0,0,2,0,1,0);
        $display("test_reset done");
    endtask

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        fails = 0;
        n_compared = 0;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        test_table();
        test_overlap();
        test_hold();
        test_reset();
        complete_run();
    end
endmodule
`default_nettype wire
